// >>> rtl/rx_address_filter_wakeup_detect.sv
// rx_address_filter_wakeup_detect: destination address filter and wakeup frame detector on the mac receive path.
// assumes a byte stream from the mac receive datapath on core_clk and an avalon-mm master for the registers.
// Behaviour
// - perfect mode: destination equals station address
// - hash index: top six crc bits
// - index msb picks register, low five bits
// - hash-only: hash check for all addresses
// - hash-perfect: physical perfect, multicast hashed
// - inverse: accept only non-matching destinations
// - pass-all-multicast accepts every multicast frame
// - promiscuous accepts every frame
// - wakeup enable stops normal reception
// - pattern match sets flag, issues wakeup
// - eight filters, forty sequential port accesses
// - wakeup needs address pass and crc match
// - offset marks first byte checked
// - 128-bit mask selects bytes after offset
// - image order: masks, commands, offsets, crcs
// - five control bits select filter mode
// - mask word 0 lsb is earliest byte
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module rx_address_filter_wakeup_detect #(
	parameter int NUM_FILTERS = rx_filter_pkg::NUM_FILTERS
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        rxValid,
	input  wire logic        rxStart,
	input  wire logic        rxEnd,
	input  wire logic [7:0]  rxData,
	output logic             rxDecide,
	output logic             rxAccept,
	output logic             remoteWakeup,
	output logic             wakeRequest
);

	////////////////////////////////////////////////////////////////////////////////
	// crc helpers
	function automatic logic [15:0] crc16Byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc;
		for (int b = 0; b < 8; b++)
			c = (c[0] ^ data[b]) ? ((c >> 1) ^ rx_filter_pkg::CRC16_POLY) : (c >> 1);
		return c;
	endfunction

	// non-reflected register fed lsb first, so the top six bits are the msbs of the register
	function automatic logic [5:0] hashIndex(input logic [47:0] da);
		logic [31:0] c;
		c = rx_filter_pkg::CRC32_INIT;
		for (int b = 0; b < 48; b++)
			c = (c[31] ^ da[b]) ? ((c << 1) ^ rx_filter_pkg::CRC32_POLY) : (c << 1);
		return c[31:26];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// registers and bus slave
	logic [rx_filter_pkg::CTRL_WIDTH-1:0] filterCtrl;
	logic [31:0]                          stationLow;
	logic [31:0]                          stationHigh;
	logic [31:0]                          hashLow;
	logic [31:0]                          hashHigh;
	logic                                 wakeEnable;
	logic                                 wakeFlag;
	logic [31:0]                          filterMem [rx_filter_pkg::IMAGE_WORDS];
	logic [5:0]                           portPtr;
	rx_filter_pkg::bus_state_t            busState;
	logic                                 wakeHit;

	wire busReq   = read | write;
	wire busDone  = busReq && (busState == rx_filter_pkg::BUS_ANSWER);
	wire wrDone   = write && busDone;
	wire portHit  = busDone && (address == rx_filter_pkg::ADDR_WAKEUP_PORT);
	wire wrCtrl   = wrDone && (address == rx_filter_pkg::ADDR_FILTER_CTRL);
	wire wrStaLo  = wrDone && (address == rx_filter_pkg::ADDR_STATION_LOW);
	wire wrStaHi  = wrDone && (address == rx_filter_pkg::ADDR_STATION_HIGH);
	wire wrHashLo = wrDone && (address == rx_filter_pkg::ADDR_HASH_LOW);
	wire wrHashHi = wrDone && (address == rx_filter_pkg::ADDR_HASH_HIGH);
	wire wrWake   = wrDone && (address == rx_filter_pkg::ADDR_WAKE_CTRL);
	wire wrPort   = write && portHit;
	wire [5:0] next_portPtr = (portPtr == 6'(rx_filter_pkg::IMAGE_WORDS - 1)) ? 6'h00 : portPtr + 6'h01;

	// one wait cycle on every access gives registered read data
	assign waitrequest = busReq && (busState == rx_filter_pkg::BUS_IDLE);

	// read mux; unmapped addresses read zero
	logic [31:0] readMux;
	always_comb
	begin
		case (address)
			rx_filter_pkg::ADDR_FILTER_CTRL:  readMux = 32'(filterCtrl);
			rx_filter_pkg::ADDR_STATION_LOW:  readMux = stationLow;
			rx_filter_pkg::ADDR_STATION_HIGH: readMux = {16'h0000, stationHigh[15:0]};
			rx_filter_pkg::ADDR_HASH_LOW:     readMux = hashLow;
			rx_filter_pkg::ADDR_HASH_HIGH:    readMux = hashHigh;
			rx_filter_pkg::ADDR_WAKE_CTRL:    readMux = {30'h0000_0000, wakeFlag, wakeEnable};
			rx_filter_pkg::ADDR_WAKEUP_PORT:  readMux = filterMem[portPtr];
			default:                          readMux = 32'h0000_0000;
		endcase
	end

	// bus answer sequencing
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busState <= rx_filter_pkg::BUS_IDLE;
			readdata <= rx_filter_pkg::WORD_RESET;
		end
		else
		begin
			busState <= (busReq && busState == rx_filter_pkg::BUS_IDLE) ? rx_filter_pkg::BUS_ANSWER
				: rx_filter_pkg::BUS_IDLE;
			if (read && busState == rx_filter_pkg::BUS_IDLE)
				readdata <= readMux;
		end
	end

	// address filter configuration
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			filterCtrl  <= rx_filter_pkg::CTRL_RESET;
			stationLow  <= rx_filter_pkg::WORD_RESET;
			stationHigh <= rx_filter_pkg::WORD_RESET;
			hashLow     <= rx_filter_pkg::WORD_RESET;
			hashHigh    <= rx_filter_pkg::WORD_RESET;
		end
		else
		begin
			if (wrCtrl)   filterCtrl  <= writedata[rx_filter_pkg::CTRL_WIDTH-1:0];
			if (wrStaLo)  stationLow  <= writedata;
			if (wrStaHi)  stationHigh <= {16'h0000, writedata[15:0]};
			if (wrHashLo) hashLow     <= writedata;
			if (wrHashHi) hashHigh    <= writedata;
		end
	end

	// wake control: a match in the same cycle as a write-one clear keeps the flag set
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wakeEnable <= 1'b0;
			wakeFlag   <= 1'b0;
		end
		else
		begin
			if (wrWake)
				wakeEnable <= writedata[rx_filter_pkg::BIT_WAKE_ENABLE];
			wakeFlag <= wakeHit | (wakeFlag & ~(wrWake & writedata[rx_filter_pkg::BIT_WAKE_RECEIVED]));
		end
	end

	// sequential filter image port: each access moves to the next word, wrapping after the last
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			portPtr <= 6'h00;
		else if (portHit)
			portPtr <= next_portPtr;
	end

	// image storage has no reset; software must load it before enabling wakeup
	always_ff @(posedge core_clk)
	begin
		if (wrPort)
			filterMem[portPtr] <= writedata;
	end

	////////////////////////////////////////////////////////////////////////////////
	// destination address capture and filter decision
	logic [rx_filter_pkg::POS_WIDTH-1:0] posCnt;
	logic [47:0]                         daShift;
	logic                                addrPass;

	wire [rx_filter_pkg::POS_WIDTH-1:0] curPos = rxStart ? '0 : posCnt;
	wire [47:0] daFull      = {rxData, daShift[47:8]};
	wire        daLast      = rxValid && (curPos == rx_filter_pkg::POS_WIDTH'(rx_filter_pkg::DA_BYTES - 1));
	wire [47:0] stationAddr = {stationHigh[15:0], stationLow};
	wire        perfectHit  = (daFull == stationAddr);
	wire        isMulticast = daFull[0];
	wire [5:0]  hashIdx     = hashIndex(daFull);
	wire [31:0] hashWord    = hashIdx[5] ? hashHigh : hashLow;
	wire        hashHit     = hashWord[hashIdx[4:0]];
	wire        hpSel       = filterCtrl[rx_filter_pkg::BIT_HASH_PERFECT];
	wire        hoSel       = filterCtrl[rx_filter_pkg::BIT_HASH_ONLY];
	wire        invSel      = filterCtrl[rx_filter_pkg::BIT_INVERSE];
	wire        promSel     = filterCtrl[rx_filter_pkg::BIT_PROMISCUOUS];
	wire        mcastSel    = filterCtrl[rx_filter_pkg::BIT_PASS_MCAST];
	wire        modeHit     = invSel ? !perfectHit
		: (hoSel && hpSel) ? hashHit
		: hpSel ? (isMulticast ? hashHit : perfectHit)
		: perfectHit;
	wire        next_pass   = promSel || (mcastSel && isMulticast) || modeHit;

	// byte position and address shifter
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			posCnt   <= '0;
			daShift  <= '0;
			addrPass <= 1'b0;
		end
		else if (rxValid)
		begin
			posCnt  <= (&curPos) ? curPos : curPos + 1'b1; // saturate on very long frames
			daShift <= daFull;
			if (daLast)
				addrPass <= next_pass;
		end
	end

	// decision pulse one cycle after the sixth address byte; wakeup mode blocks normal reception
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rxDecide <= 1'b0;
			rxAccept <= 1'b0;
		end
		else
		begin
			rxDecide <= daLast;
			if (daLast)
				rxAccept <= next_pass && !wakeEnable;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// wakeup pattern filters
	logic [NUM_FILTERS-1:0] filterMatch;

	for (genvar f = 0; f < NUM_FILTERS; f++)
	begin : g_filter
		logic [15:0] crcReg;
		wire  [7:0]  cmdByte  = filterMem[rx_filter_pkg::CMD_BASE + f/4][8*(f%4) +: 8];
		wire  [7:0]  offset   = filterMem[rx_filter_pkg::OFFSET_BASE + f/4][8*(f%4) +: 8];
		wire  [15:0] expected = filterMem[rx_filter_pkg::CRC16_BASE + f/2][16*(f%2) +: 16];
		wire  [rx_filter_pkg::POS_WIDTH-1:0] rel = curPos - rx_filter_pkg::POS_WIDTH'(offset);
		wire  inWindow = (curPos >= rx_filter_pkg::POS_WIDTH'(offset))
			&& (rel < rx_filter_pkg::POS_WIDTH'(rx_filter_pkg::MASK_BYTES));
		wire  [31:0] maskWord = filterMem[rx_filter_pkg::MASK_WORDS*f + 32'(rel[6:5])];
		wire  byteUsed = inWindow && maskWord[rel[4:0]];
		wire  [15:0] crcBase = rxStart ? rx_filter_pkg::CRC16_INIT : crcReg;
		wire  [15:0] next_crc = byteUsed ? crc16Byte(crcBase, rxData) : crcBase;

		always_ff @(posedge core_clk or negedge reset_n)
		begin
			if (!reset_n)
				crcReg <= rx_filter_pkg::CRC16_INIT;
			else if (rxValid)
				crcReg <= next_crc;
		end

		assign filterMatch[f] = cmdByte[rx_filter_pkg::CMD_ENABLE_BIT] && (next_crc == expected);
	end

	// a wakeup frame must end after its address was seen and pass the address check
	wire addrKnown = (posCnt > rx_filter_pkg::POS_WIDTH'(rx_filter_pkg::DA_BYTES - 1)) && !rxStart;
	assign wakeHit = wakeEnable && rxValid && rxEnd && addrKnown && addrPass && (|filterMatch);

	// wakeup pulse; the flag stays until software clears it and software ends wakeup mode itself
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			remoteWakeup <= 1'b0;
		else
			remoteWakeup <= wakeHit;
	end

	assign wakeRequest = wakeFlag;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_wake_blocks_rx:  assert property (rxDecide && $past(wakeEnable) |-> !rxAccept)
		else $error("frame accepted during wakeup mode");
	a_promisc_all:     assert property (daLast && promSel && !wakeEnable |=> rxDecide && rxAccept)
		else $error("promiscuous frame rejected");
	a_mcast_pass:      assert property (daLast && mcastSel && isMulticast && !wakeEnable |=> rxAccept)
		else $error("multicast frame rejected with pass-all set");
	a_inverse_rej:     assert property (daLast && filterCtrl == 5'h04 && perfectHit |=> !rxAccept)
		else $error("inverse mode accepted station address");
	a_perfect_match:   assert property (daLast && filterCtrl == 5'h00 && !wakeEnable |=> rxAccept == $past(perfectHit))
		else $error("perfect mode decision wrong");
	a_hash_only:       assert property (daLast && filterCtrl == 5'h03 && !wakeEnable |=> rxAccept == $past(hashHit))
		else $error("hash-only decision wrong");
	a_hash_perfect:    assert property (daLast && filterCtrl == 5'h01 && !isMulticast && !wakeEnable
		|=> rxAccept == $past(perfectHit))
		else $error("hash-perfect physical decision wrong");
	a_wake_flag_set:   assert property (wakeHit |=> wakeFlag && remoteWakeup ##1 (!remoteWakeup || $past(wakeHit)))
		else $error("wakeup match did not set flag and pulse");
	a_wake_needs_addr: assert property (remoteWakeup |-> $past(addrPass && wakeEnable))
		else $error("wakeup without address pass");
	a_port_wrap:       assert property (portHit && portPtr == 6'h27 |=> portPtr == 6'h00)
		else $error("filter port pointer did not wrap after forty");

	c_wake_seen:     cover property (remoteWakeup);
	c_hash_accept:   cover property (rxDecide && rxAccept && filterCtrl == 5'h03);
	c_port_full:     cover property (portHit && portPtr == 6'h27);
	c_inverse_pass:  cover property (rxDecide && rxAccept && filterCtrl == 5'h04);

endmodule

// >>> rtl/rx_filter_pkg.sv
// rx_filter_pkg: register map, field positions, reset values and codes for the receive address filter.
// assumes a 32-bit avalon-mm register bus with word-aligned byte addresses.
package rx_filter_pkg;
	// register byte addresses
	localparam logic [4:0] ADDR_FILTER_CTRL   = 5'h00;
	localparam logic [4:0] ADDR_STATION_LOW   = 5'h04;
	localparam logic [4:0] ADDR_STATION_HIGH  = 5'h08;
	localparam logic [4:0] ADDR_HASH_LOW      = 5'h0C;
	localparam logic [4:0] ADDR_HASH_HIGH     = 5'h10;
	localparam logic [4:0] ADDR_WAKE_CTRL     = 5'h14;
	localparam logic [4:0] ADDR_WAKEUP_PORT   = 5'h18;
	// filter control bit positions
	localparam int BIT_HASH_PERFECT  = 0;
	localparam int BIT_HASH_ONLY     = 1;
	localparam int BIT_INVERSE       = 2;
	localparam int BIT_PROMISCUOUS   = 3;
	localparam int BIT_PASS_MCAST    = 4;
	localparam int CTRL_WIDTH        = 5;
	// wake control/status bit positions
	localparam int BIT_WAKE_ENABLE   = 0;
	localparam int BIT_WAKE_RECEIVED = 1;
	// reset values
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	// wakeup filter image layout
	localparam int NUM_FILTERS     = 8;
	localparam int IMAGE_WORDS     = 40;
	localparam int MASK_WORDS      = 4;
	localparam int CMD_BASE        = 32;
	localparam int OFFSET_BASE     = 34;
	localparam int CRC16_BASE      = 36;
	localparam int MASK_BYTES      = 128;
	localparam int CMD_ENABLE_BIT  = 0;
	// destination address length and byte position counter
	localparam int DA_BYTES        = 6;
	localparam int POS_WIDTH       = 11;
	// crc constants (crc16 reflected, crc32 in normal form, bits taken lsb first as on the wire)
	localparam logic [15:0] CRC16_POLY = 16'hA001;
	localparam logic [15:0] CRC16_INIT = 16'hFFFF;
	localparam logic [31:0] CRC32_POLY = 32'h04C1_1DB7;
	localparam logic [31:0] CRC32_INIT = 32'hFFFF_FFFF;
	// bus answer states
	typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage

// >>> tb/rx_frame_source.sv
// rx_frame_source: receive datapath model, hands frames over one byte per edge with optional idle gaps.
// assumes the caller enters sendFrame just after a rising edge of core_clk.
`timescale 1ns/1ps
module rx_frame_source (
	input  wire logic core_clk,
	output logic      rxValid,
	output logic      rxStart,
	output logic      rxEnd,
	output logic [7:0] rxData
);
	logic [7:0] dataReg = 8'h00;
	logic [7:0] idlePat = 8'hA5;

	// quiet lines at time zero
	initial
	begin
		rxValid = 1'b0;
		rxStart = 1'b0;
		rxEnd = 1'b0;
	end
	////////////////////////////////////////////////////////////
	// idle data flips every cycle so a stale byte is never mistaken for a real one
	always @(posedge core_clk)
		idlePat <= ~idlePat;
	assign rxData = rxValid ? dataReg : idlePat;
	////////////////////////////////////////////////////////////
	// one byte per edge; a set bit in gaps inserts one idle cycle after that byte
	task automatic sendFrame(input logic [7:0] f [0:63], input int len, input logic [31:0] gaps);
	begin
		for (int k = 0; k < len; k++)
		begin
			rxValid <= 1'b1;
			rxStart <= (k == 0);
			rxEnd <= (k == len - 1);
			dataReg <= f[k];
			@(posedge core_clk);
			if (gaps[k % 32])
			begin
				rxValid <= 1'b0;
				@(posedge core_clk);
			end
		end
		rxValid <= 1'b0;
	end
	endtask
endmodule

// >>> tb/test_rx_address_filter_wakeup_detect.sv
// test_rx_address_filter_wakeup_detect: register checks, random filter modes, wakeup pattern match.
// assumes rx_frame_source drives the receive path; expectations come from bench functions.
`timescale 1ns/1ps
module test_rx_address_filter_wakeup_detect;
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [4:0]  address = 5'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, rd;
	logic        waitrequest, rxValid, rxStart, rxEnd, rxDecide, rxAccept, remoteWakeup, wakeRequest, lastAccept;
	logic [7:0]  rxData;
	logic [7:0]  fr [0:63];
	logic [31:0] img [0:39];
	logic [47:0] sta, da;
	logic [63:0] hash;
	logic [4:0]  ctrl;
	integer      seed = 32'h1E95;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          nDecide = 0;
	int          nWake = 0;
	int          cycles = 0;
	int          w0;

	always #5 core_clk = ~core_clk;

	rx_address_filter_wakeup_detect i_rx_address_filter_wakeup_detect (.core_clk(core_clk), .reset_n(reset_n),
		.address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .rxValid(rxValid), .rxStart(rxStart), .rxEnd(rxEnd), .rxData(rxData),
		.rxDecide(rxDecide), .rxAccept(rxAccept), .remoteWakeup(remoteWakeup), .wakeRequest(wakeRequest));
	rx_frame_source i_rx_frame_source (.core_clk(core_clk), .rxValid(rxValid), .rxStart(rxStart),
		.rxEnd(rxEnd), .rxData(rxData));
	////////////////////////////////////////////////////////////
	// decision and wakeup pulses are counted, so a missing or doubled pulse shows
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (rxDecide === 1'b1)
		begin
			nDecide <= nDecide + 1;
			lastAccept <= rxAccept;
		end
		if (remoteWakeup === 1'b1)
			nWake <= nWake + 1;
		if (cycles == 20000)
		begin
			n_mismatch = n_mismatch + 1;
			test_done();
		end
	end

	task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
	begin
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic checkFlag(input logic got, input logic exp);
	begin
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	end
	endtask

	// request held until waitrequest is seen low at an edge, then released
	task automatic busXfer(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] q);
	begin
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= wd;
		do
			@(posedge core_clk);
		while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		@(posedge core_clk);
	end
	endtask

	task automatic sendCheck(input int len, input logic expAcc);
	int d0;
	begin
		d0 = nDecide;
		i_rx_frame_source.sendFrame(fr, len, $random(seed));
		repeat (3) @(posedge core_clk);
		checkFlag(nDecide == d0 + 1, 1'b1);
		checkFlag(lastAccept, expAcc);
	end
	endtask

	task automatic buildFrame(input logic [47:0] a);
	begin
		for (int k = 0; k < 64; k++)
			fr[k] = (k < 6) ? a[8 * k +: 8] : 8'($random(seed));
	end
	endtask

	// hash crc over the destination, bits taken lsb first
	function automatic logic [5:0] hashIdx(input logic [47:0] a);
		logic [31:0] c;
		c = rx_filter_pkg::CRC32_INIT;
		for (int i = 0; i < 48; i++)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i]) ? rx_filter_pkg::CRC32_POLY : 32'h0);
		return c[31:26];
	endfunction

	function automatic logic expAccept(input logic [4:0] m, input logic [47:0] a);
		logic hit;
		hit = hash[hashIdx(a)];
		return m[3] ? 1'b1 : (m[4] && a[0]) ? 1'b1 : m[2] ? (a != sta) :
			(m[1] && m[0]) ? hit : (m[0] && a[0]) ? hit : (a == sta);
	endfunction

	function automatic logic [15:0] crc16(input logic [31:0] mk, input int off);
		logic [15:0] c;
		c = rx_filter_pkg::CRC16_INIT;
		for (int j = 0; j < 32; j++)
			for (int b = 0; b < 8; b++)
				if (mk[j])
					c = (c >> 1) ^ ((c[0] ^ fr[off + j][b]) ? rx_filter_pkg::CRC16_POLY : 16'h0);
		return c;
	endfunction

	task automatic test_done();
	begin
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		busXfer(1'b1, 5'h1C, 32'hFFFF_FFFF, rd);
		for (int a = 0; a < 8; a++)
			if (a != 6)
			begin
				busXfer(1'b0, 5'(4 * a), 32'h0, rd);
				checkWord(rd, 32'h0);
			end
		$display("test register reset done");
		sta = 48'({$random(seed), $random(seed)}) & 48'hFFFF_FFFF_FFFE;
		busXfer(1'b1, rx_filter_pkg::ADDR_STATION_LOW, sta[31:0], rd);
		busXfer(1'b1, rx_filter_pkg::ADDR_STATION_HIGH, {16'h0, sta[47:32]}, rd);
		// first five passes set each control bit alone, then random combinations
		for (int t = 0; t < 48; t++)
		begin
			ctrl = (t < 5) ? 5'(1 << t) : 5'($random(seed));
			hash = {$random(seed), $random(seed)};
			da = 48'({$random(seed), $random(seed)});
			// random destinations alternate physical and multicast
			da = (t % 4 == 0) ? sta : (t % 4 == 1) ? 48'hFFFF_FFFF_FFFF : {da[47:1], t[0]};
			busXfer(1'b1, rx_filter_pkg::ADDR_FILTER_CTRL, {27'h0, ctrl}, rd);
			busXfer(1'b1, rx_filter_pkg::ADDR_HASH_LOW, hash[31:0], rd);
			busXfer(1'b1, rx_filter_pkg::ADDR_HASH_HIGH, hash[63:32], rd);
			busXfer(1'b0, rx_filter_pkg::ADDR_FILTER_CTRL, 32'h0, rd);
			checkWord(rd, {27'h0, ctrl});
			buildFrame(da);
			sendCheck(7 + ($random(seed) & 7), expAccept(ctrl, da));
		end
		$display("test filter modes done");
		busXfer(1'b1, rx_filter_pkg::ADDR_FILTER_CTRL, 32'h0, rd);
		buildFrame(sta);
		for (int w = 0; w < 40; w++)
			img[w] = (w > 0 && w < 4) ? 32'h0 : $random(seed);
		img[0] = (img[0] & 32'h0003_FFFF) | 32'h101;
		img[32] = 32'h1;
		img[33] = 32'h0;
		img[34] = 32'h2;
		img[36] = {img[36][31:16], crc16(img[0], 2)};
		for (int w = 0; w < 40; w++)
			busXfer(1'b1, rx_filter_pkg::ADDR_WAKEUP_PORT, img[w], rd);
		for (int w = 0; w < 40; w++)
		begin
			busXfer(1'b0, rx_filter_pkg::ADDR_WAKEUP_PORT, 32'h0, rd);
			checkWord(rd, img[w]);
		end
		busXfer(1'b1, rx_filter_pkg::ADDR_WAKE_CTRL, 32'h1, rd);
		// a flipped masked byte past the address must spoil the crc match; an unmasked one must not
		w0 = nWake;
		fr[10] = ~fr[10];
		sendCheck(24, 1'b0);
		checkFlag(nWake == w0, 1'b1);
		fr[10] = ~fr[10];
		fr[22] = ~fr[22];
		sendCheck(24, 1'b0);
		checkFlag(nWake == w0 + 1, 1'b1);
		checkFlag(wakeRequest, 1'b1);
		busXfer(1'b0, rx_filter_pkg::ADDR_WAKE_CTRL, 32'h0, rd);
		checkWord(rd, 32'h3);
		busXfer(1'b1, rx_filter_pkg::ADDR_WAKE_CTRL, 32'h3, rd);
		busXfer(1'b0, rx_filter_pkg::ADDR_WAKE_CTRL, 32'h0, rd);
		checkWord(rd, 32'h1);
		busXfer(1'b1, rx_filter_pkg::ADDR_WAKE_CTRL, 32'h0, rd);
		sendCheck(24, 1'b1);
		checkFlag(wakeRequest, 1'b0);
		$display("test wakeup done");
		test_done();
	end
endmodule
